/* File: ast_pkg.sv */
// Package: constants and types for the async serial transmitter block
//
// Overview of operation
// - Character length 8 or 9 bits; ninth bit comes from tx_ninth_bit.
// - Each data frame gets one start bit and one stop bit.
// - Buffer-to-shifter transfer sets tx_buffer_empty_flag.
// - Next transfer happens 9/16 bit time into previous stop bit.
// - Divisor zero stops baud ticks; high divisor applies on low write.
// - tx_buffer_empty_flag reads set after reset.
// - Software writes only when empty; device sends only after clear.
// - Enable rising edge queues preamble of 10 or 11 ones first.
// - Start bit 0 in LSB, stop bit 1 in bit 9 (8-bit) or MSB (9-bit) of shifter.
// - Optional odd or even parity replaces the top data bit.
// - Empty flag with tx_irq_on raises transmitter interrupt request.
// - Serial output idles at 1 outside frames.
// - Clearing enable mid frame still finishes that frame.
// - Enable toggled during frame queues one idle character.
// - While break_send, load all-zero break characters of set length.
// - After break_send clears, finish break then send ones.
// - Received break sets framing and full flags, clears data.
// - Idle character or preamble is all ones of set length.
// - Enable clear and shifter idle releases the serial pin.
// - Receiver takes 8 or 9 bits; ninth bit kept in rx_ninth_bit.
// - 13-bit divisor makes baud clock; bit rate is that over 16.
package ast_pkg;
   localparam int DIV_W = 13;
   localparam int DIVH_W = 5;
   localparam int FRM_W = 11;
   localparam logic [2:0] ADR_DIV_HI = 3'h0;
   localparam logic [2:0] ADR_DIV_LO = 3'h1;
   localparam logic [2:0] ADR_CR1 = 3'h2;
   localparam logic [2:0] ADR_CR2 = 3'h3;
   localparam logic [2:0] ADR_SR1 = 3'h4;
   localparam logic [2:0] ADR_DRH = 3'h5;
   localparam logic [2:0] ADR_DRL = 3'h6;
   localparam int CR1_M = 4;
   localparam int CR1_PEN = 1;
   localparam int CR1_ODD = 0;
   localparam int CR2_TIE = 7;
   localparam int CR2_TE = 3;
   localparam int CR2_RE = 2;
   localparam int CR2_SBK = 0;
   localparam int SR1_TX_BUFFER_EMPTY_FLAG = 7;
   localparam int SR1_TC = 6;
   localparam int SR1_RX_FULL_FLAG = 5;
   localparam int SR1_FE = 1;
   localparam int DRH_R8 = 7;
   localparam int DRH_T8 = 6;
   localparam logic [7:0] REG_RST = 8'h00;
   localparam logic [DIV_W-1:0] DIV_RST = 13'h0000;
   localparam logic [3:0] LEN8 = 4'ha;
   localparam logic [3:0] LEN9 = 4'hb;
   localparam logic [3:0] LAST_BIT = 4'h1;
   localparam logic [3:0] PH_XFER = 4'h9;
   localparam logic [3:0] PH_LAST = 4'hf;
   localparam logic [3:0] RX_SMP = 4'h8;
   localparam logic [3:0] RX_STOP8 = 4'h9;
   localparam logic [3:0] RX_STOP9 = 4'ha;
   typedef enum logic [1:0] {
      K_IDLE = 2'b00,
      K_DATA = 2'b01,
      K_BRK  = 2'b10
   } ast_kind_type;
   typedef struct packed {
      ast_kind_type     kind;
      logic [3:0]       len;
      logic [FRM_W-1:0] bits;
   } ast_frame_type;
   typedef enum logic {
      RX_IDLE = 1'b0,
      RX_BITS = 1'b1
   } ast_rx_state_type;
endpackage

/* File: ast_serial_top.sv */
// Module: async serial transmitter with break-aware receiver and regs
module ast_serial_top
   import ast_pkg::*;
(
   input  wire logic       I_CORE_CLK,
   input  wire logic       I_RST,
   input  wire logic [2:0] I_ADDR,
   input  wire logic [7:0] I_WDATA,
   input  wire logic       I_WR,
   input  wire logic       I_RD,
   input  wire logic       I_RXD,
   output logic      [7:0] O_RDATA,
   output logic            O_TXD,
   output logic            O_TXD_OE,
   output logic            O_TX_IRQ
);
   logic [DIV_W-1:0]  div_ff;
   logic [DIVH_W-1:0] div_hi_pend_ff;
   logic [7:0]        cr1_ff;
   logic [7:0]        cr2_ff;
   logic [7:0]        buf_lo_ff;
   logic              tx_ninth_bit_ff;
   logic [DIV_W-1:0]  rt_cnt_ff;
   logic              rt_tick_ff;
   logic              tx_buffer_empty_flag_ff;
   logic              tx_on_q_ff;
   logic              pre_pend_ff;
   logic              was_brk_ff;
   logic              busy_ff;
   logic [FRM_W-1:0]  shift_ff;
   logic [3:0]        bits_left_ff;
   logic [3:0]        phase_ff;
   ast_frame_type     nxt_frame_ff;
   logic              nxt_valid_ff;
   ast_frame_type     cand;
   logic              cand_ok;
   logic              xfer_pt;
   logic              end_pt;
   logic              decide_now;
   logic              start_now;
   logic              par8;
   logic              par9;
   logic              tx_on;
   logic              break_send;
   logic              m9;
   ast_rx_state_type  rx_state_ff;
   logic [3:0]        rx_phase_ff;
   logic [3:0]        rx_cnt_ff;
   logic [8:0]        rx_shift_ff;
   logic [7:0]        rx_data_ff;
   logic              rx_ninth_bit_ff;
   logic              rx_full_flag_ff;
   logic              framing_err_flag_ff;
   logic              rxd_prev_ff;
   logic              rx_fin;
   logic              rx_brk;
   logic [3:0]        rx_stop;
   logic              rd_drl;
   logic [7:0]        rd_val;

   assign m9 = cr1_ff[CR1_M];
   assign tx_on = cr2_ff[CR2_TE];
   assign break_send = cr2_ff[CR2_SBK];
   assign rd_drl = I_RD && (I_ADDR == ADR_DRL);

   // Configuration writes; high divisor waits for low half
   always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
      if (I_RST) begin
         div_ff <= DIV_RST;
         div_hi_pend_ff <= DIV_RST[DIV_W-1:8];
         cr1_ff <= REG_RST;
         cr2_ff <= REG_RST;
      end else if (I_WR) begin
         unique case (I_ADDR)
            ADR_DIV_HI: div_hi_pend_ff <= I_WDATA[DIVH_W-1:0];
            ADR_DIV_LO: div_ff <= {div_hi_pend_ff, I_WDATA};
            ADR_CR1:    cr1_ff <= I_WDATA;
            ADR_CR2:    cr2_ff <= I_WDATA;
            default:    ;
         endcase
      end
   end

   // Transmit buffer; ninth bit persists until rewritten
   always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
      if (I_RST) begin
         buf_lo_ff <= REG_RST;
         tx_ninth_bit_ff <= 1'b0;
      end else if (I_WR) begin
         if (I_ADDR == ADR_DRL) begin
            buf_lo_ff <= I_WDATA;
         end
         if (I_ADDR == ADR_DRH) begin
            tx_ninth_bit_ff <= I_WDATA[DRH_T8];
         end
      end
   end

   // Baud counter gives the 16x tick; zero divisor holds it still
   always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
      if (I_RST) begin
         rt_cnt_ff <= DIV_RST;
         rt_tick_ff <= 1'b0;
      end else if (div_ff == DIV_RST) begin
         rt_cnt_ff <= DIV_RST;
         rt_tick_ff <= 1'b0;
      end else if (rt_cnt_ff >= div_ff - 13'h0001) begin
         rt_cnt_ff <= DIV_RST;
         rt_tick_ff <= 1'b1;
      end else begin
         rt_cnt_ff <= rt_cnt_ff + 13'h0001;
         rt_tick_ff <= 1'b0;
      end
   end

   // Parity over the data bits below the one it replaces
   assign par8 = (^buf_lo_ff[6:0]) ^ cr1_ff[CR1_ODD];
   assign par9 = (^buf_lo_ff) ^ cr1_ff[CR1_ODD];

   // Pick what the shifter loads next, preamble first
   always_comb begin
      cand.kind = K_IDLE;
      cand.len = m9 ? LEN9 : LEN8;
      cand.bits = '1;
      cand_ok = 1'b0;
      if (pre_pend_ff && tx_on) begin
         cand_ok = 1'b1;
      end else if (break_send && tx_on) begin
         cand.kind = K_BRK;
         cand.bits = '0;
         cand_ok = 1'b1;
      end else if (was_brk_ff) begin
         cand_ok = 1'b1;
      end else if (!tx_buffer_empty_flag_ff && tx_on) begin
         cand.kind = K_DATA;
         cand_ok = 1'b1;
         if (m9) begin
            cand.bits = {1'b1, cr1_ff[CR1_PEN] ? par9 : tx_ninth_bit_ff,
                         buf_lo_ff, 1'b0};
         end else begin
            cand.bits = {2'b11, cr1_ff[CR1_PEN] ? par8 : buf_lo_ff[7],
                         buf_lo_ff[6:0], 1'b0};
         end
      end
   end

   // Transfer point sits 9/16 into the stop bit of a running frame
   assign xfer_pt = busy_ff && (bits_left_ff == LAST_BIT)
                    && (phase_ff == PH_XFER);
   assign end_pt = rt_tick_ff && busy_ff && (phase_ff == PH_LAST);
   assign decide_now = rt_tick_ff && cand_ok && !nxt_valid_ff
                       && (!busy_ff || xfer_pt);
   // A queued frame waits for the end of the current stop bit
   assign start_now = nxt_valid_ff && (!busy_ff
                      || (end_pt && (bits_left_ff == LAST_BIT)));

   // Holding stage between decision and shifter load
   always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
      if (I_RST) begin
         nxt_frame_ff <= '0;
         nxt_valid_ff <= 1'b0;
      end else if (decide_now) begin
         nxt_frame_ff <= cand;
         nxt_valid_ff <= 1'b1;
      end else if (start_now) begin
         nxt_valid_ff <= 1'b0;
      end
   end

   // Shifter; LSB first, one bit per 16 ticks, refills with ones
   always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
      if (I_RST) begin
         busy_ff <= 1'b0;
         shift_ff <= '1;
         bits_left_ff <= 4'h0;
         phase_ff <= 4'h0;
      end else if (start_now) begin
         busy_ff <= 1'b1;
         shift_ff <= nxt_frame_ff.bits;
         bits_left_ff <= nxt_frame_ff.len;
         phase_ff <= 4'h0;
      end else if (rt_tick_ff && busy_ff) begin
         phase_ff <= phase_ff + 4'h1;
         if (phase_ff == PH_LAST) begin
            shift_ff <= {1'b1, shift_ff[FRM_W-1:1]};
            bits_left_ff <= bits_left_ff - 4'h1;
            if (bits_left_ff == LAST_BIT) begin
               busy_ff <= 1'b0;
            end
         end
      end
   end

   // Empty flag: set on data transfer, cleared by a low data write
   // A transfer in the same cycle as a write wins over the clear
   always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
      if (I_RST) begin
         tx_buffer_empty_flag_ff <= 1'b1;
      end else if (decide_now && cand.kind == K_DATA) begin
         tx_buffer_empty_flag_ff <= 1'b1;
      end else if (I_WR && I_ADDR == ADR_DRL) begin
         tx_buffer_empty_flag_ff <= 1'b0;
      end
   end

   // Enable edge queues a preamble; break history forces a ones tail
   always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
      if (I_RST) begin
         tx_on_q_ff <= 1'b0;
         pre_pend_ff <= 1'b0;
         was_brk_ff <= 1'b0;
      end else begin
         tx_on_q_ff <= tx_on;
         if (tx_on && !tx_on_q_ff) begin
            pre_pend_ff <= 1'b1;
         end else if (decide_now && cand.kind == K_IDLE) begin
            pre_pend_ff <= 1'b0;
         end
         if (decide_now) begin
            was_brk_ff <= (cand.kind == K_BRK);
         end
      end
   end

   // Pin drive; the enable drops once idle with enable clear
   always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
      if (I_RST) begin
         O_TXD <= 1'b1;
         O_TXD_OE <= 1'b0;
         O_TX_IRQ <= 1'b0;
      end else begin
         O_TXD <= busy_ff ? shift_ff[0] : 1'b1;
         O_TXD_OE <= tx_on || busy_ff || nxt_valid_ff;
         O_TX_IRQ <= tx_buffer_empty_flag_ff && cr2_ff[CR2_TIE];
      end
   end

   // Receiver finish point and break
   assign rx_stop = m9 ? RX_STOP9 : RX_STOP8;
   assign rx_fin = rt_tick_ff && (rx_state_ff == RX_BITS)
                   && (rx_phase_ff == RX_SMP) && (rx_cnt_ff == rx_stop);
   assign rx_brk = !I_RXD && (m9 ? (rx_shift_ff == 9'h000)
                   : (rx_shift_ff[8:1] == 8'h00));

   // Receiver sampling at mid-bit; new start needs a falling edge
   always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
      if (I_RST) begin
         rx_state_ff <= RX_IDLE;
         rx_phase_ff <= 4'h0;
         rx_cnt_ff <= 4'h0;
         rx_shift_ff <= 9'h000;
         rxd_prev_ff <= 1'b1;
      end else if (rt_tick_ff) begin
         rxd_prev_ff <= I_RXD;
         unique case (rx_state_ff)
            RX_IDLE: begin
               if (cr2_ff[CR2_RE] && rxd_prev_ff && !I_RXD) begin
                  rx_state_ff <= RX_BITS;
                  rx_phase_ff <= 4'h0;
                  rx_cnt_ff <= 4'h0;
               end
            end
            RX_BITS: begin
               rx_phase_ff <= rx_phase_ff + 4'h1;
               if (rx_phase_ff == RX_SMP) begin
                  rx_cnt_ff <= rx_cnt_ff + 4'h1;
                  if (rx_cnt_ff == 4'h0 && I_RXD) begin
                     rx_state_ff <= RX_IDLE; // False start
                  end else if (rx_cnt_ff == rx_stop) begin
                     rx_state_ff <= RX_IDLE;
                  end else if (rx_cnt_ff != 4'h0) begin
                     rx_shift_ff <= {I_RXD, rx_shift_ff[8:1]};
                  end
               end
            end
         endcase
      end
   end

   // Received data and ninth bit; a break clears both
   always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
      if (I_RST) begin
         rx_data_ff <= REG_RST;
         rx_ninth_bit_ff <= 1'b0;
      end else if (rx_fin) begin
         if (rx_brk) begin
            rx_data_ff <= REG_RST;
            rx_ninth_bit_ff <= 1'b0;
         end else if (m9) begin
            rx_data_ff <= rx_shift_ff[7:0];
            rx_ninth_bit_ff <= rx_shift_ff[8];
         end else begin
            rx_data_ff <= rx_shift_ff[8:1];
            rx_ninth_bit_ff <= 1'b0;
         end
      end
   end

   // Receive flags; a new frame wins over the clearing read
   always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
      if (I_RST) begin
         rx_full_flag_ff <= 1'b0;
         framing_err_flag_ff <= 1'b0;
      end else if (rx_fin) begin
         rx_full_flag_ff <= 1'b1;
         framing_err_flag_ff <= !I_RXD;
      end else if (rd_drl) begin
         rx_full_flag_ff <= 1'b0;
         framing_err_flag_ff <= 1'b0;
      end
   end

   // Read mux; unmapped address reads zero
   always_comb begin
      rd_val = REG_RST;
      unique case (I_ADDR)
         ADR_DIV_HI: rd_val[DIVH_W-1:0] = div_ff[DIV_W-1:8];
         ADR_DIV_LO: rd_val = div_ff[7:0];
         ADR_CR1:    rd_val = cr1_ff;
         ADR_CR2:    rd_val = cr2_ff;
         ADR_SR1: begin
            rd_val[SR1_TX_BUFFER_EMPTY_FLAG] = tx_buffer_empty_flag_ff;
            rd_val[SR1_TC] = !busy_ff && !nxt_valid_ff;
            rd_val[SR1_RX_FULL_FLAG] = rx_full_flag_ff;
            rd_val[SR1_FE] = framing_err_flag_ff;
         end
         ADR_DRH: begin
            rd_val[DRH_R8] = rx_ninth_bit_ff;
            rd_val[DRH_T8] = tx_ninth_bit_ff;
         end
         ADR_DRL:    rd_val = rx_data_ff;
         default:    rd_val = REG_RST;
      endcase
   end

   // Read data stands only in the cycle after the strobe
   always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
      if (I_RST) begin
         O_RDATA <= REG_RST;
      end else begin
         O_RDATA <= I_RD ? rd_val : REG_RST;
      end
   end

   default clocking cb @(posedge I_CORE_CLK); endclocking
   default disable iff (I_RST);

   property p_tx_buffer_empty_flag_set;
      decide_now && cand.kind == K_DATA |=> tx_buffer_empty_flag_ff;
   endproperty
   a_tx_buffer_empty_flag_set: assert property (p_tx_buffer_empty_flag_set)
      else $error("empty flag not set on transfer");

   property p_no_send_full;
      decide_now && cand.kind == K_DATA |-> !tx_buffer_empty_flag_ff;
   endproperty
   a_no_send_full: assert property (p_no_send_full)
      else $error("transfer from an empty buffer");

   property p_xfer_time;
      decide_now && busy_ff |-> bits_left_ff == LAST_BIT
                                && phase_ff == PH_XFER;
   endproperty
   a_xfer_time: assert property (p_xfer_time)
      else $error("transfer outside stop bit point");

   property p_div_zero;
      div_ff == DIV_RST |=> !rt_tick_ff;
   endproperty
   a_div_zero: assert property (p_div_zero)
      else $error("baud tick with zero divisor");

   property p_irq;
      tx_buffer_empty_flag_ff && cr2_ff[CR2_TIE] ##1
      tx_buffer_empty_flag_ff |-> O_TX_IRQ;
   endproperty
   a_irq: assert property (p_irq)
      else $error("missing transmit interrupt");

   property p_idle_high;
      !busy_ff |=> O_TXD;
   endproperty
   a_idle_high: assert property (p_idle_high)
      else $error("line low while idle");

   property p_frame_shape;
      start_now && nxt_frame_ff.kind == K_DATA |=>
      !shift_ff[0] && shift_ff[bits_left_ff - 4'h1];
   endproperty
   a_frame_shape: assert property (p_frame_shape)
      else $error("bad start or stop bit");

   // Enable dropping before the last bit must leave the shifter running
   property p_finish;
      busy_ff && $fell(tx_on) && (bits_left_ff > LAST_BIT) |=> busy_ff;
   endproperty
   a_finish: assert property (p_finish)
      else $error("frame cut by enable clear");

   property p_preamble;
      tx_on && !tx_on_q_ff |=> pre_pend_ff;
   endproperty
   a_preamble: assert property (p_preamble)
      else $error("preamble not queued");

   property p_release;
      !tx_on && !busy_ff && !nxt_valid_ff |=> !O_TXD_OE;
   endproperty
   a_release: assert property (p_release)
      else $error("pin still driven when done");

   property p_rx_break;
      rx_fin && rx_brk |=> framing_err_flag_ff && rx_full_flag_ff
                          && rx_data_ff == REG_RST;
   endproperty
   a_rx_break: assert property (p_rx_break)
      else $error("break not recognised");
endmodule

/* File: ast_remote_model.sv */
// Remote serial peer: catches frames from the line and sends frames back
module ast_remote_model
(
   input  wire logic i_clk,
   input  wire logic i_txd,
   input  wire logic i_nine,
   output logic      o_rxd
);
   timeunit 1ns;
   timeprecision 1ps;
   localparam int BIT_CYC = 16;
   logic [10:0] got_q[$];

   // Receive line rests high between our own frames
   initial begin
      o_rxd = 1'b1;
   end

   // Catcher: start edge, then one mid-bit sample per bit period, LSB first
   initial begin : catcher
      logic [10:0] fr;
      int          n;
      forever begin
         @(negedge i_txd);
         n = i_nine ? 11 : 10;
         fr = '0;
         repeat (BIT_CYC / 2) @(posedge i_clk);
         for (int k = 0; k < n; k++) begin
            fr[k] = i_txd;
            if (k < n - 1) begin
               repeat (BIT_CYC) @(posedge i_clk);
            end
         end
         got_q.push_back(fr);
      end
   end

   // Sender: each bit held a full period, line returned high afterwards
   task automatic send(input logic [10:0] fr, input int n);
      for (int k = 0; k < n; k++) begin
         @(posedge i_clk);
         o_rxd <= fr[k];
         repeat (BIT_CYC - 1) @(posedge i_clk);
      end
      @(posedge i_clk);
      o_rxd <= 1'b1;
   endtask
endmodule

/* File: test_async_serial_transmitter.sv */
// Self-checking bench for the async serial transmitter top
module test_async_serial_transmitter
   import ast_pkg::*;
   ;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk;
   logic        rst;
   logic [2:0]  addr;
   logic [7:0]  wdata;
   logic        wr;
   logic        rd;
   logic [7:0]  rdata;
   logic        txd;
   logic        oe;
   logic        irq;
   logic        rxd;
   logic        nine;
   logic [7:0]  d;
   logic [10:0] fr;
   int          n;
   int          t0;
   int          n_mismatch;
   int          tests_run;
   int          cyc;

   ast_serial_top i_dut (
      .I_CORE_CLK(clk), .I_RST(rst), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr),
      .I_RD(rd), .I_RXD(rxd), .O_RDATA(rdata), .O_TXD(txd), .O_TXD_OE(oe),
      .O_TX_IRQ(irq)
   );
   ast_remote_model i_peer (.i_clk(clk), .i_txd(txd), .i_nine(nine), .o_rxd(rxd));

   // 40 ns clock
   always #20 clk = ~clk;

   // Watchdog: a hang counts as a mismatch
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         n_mismatch++;
         report_and_stop();
      end
   end

   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      tests_run++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask

   // Bus cycles: strobe for one cycle, read data in the following cycle only
   task automatic wr_reg(input logic [2:0] a, input logic [7:0] v);
      @(posedge clk);
      addr <= a;
      wdata <= v;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask

   task automatic rd_reg(input logic [2:0] a, output logic [7:0] v);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      v = rdata;
   endtask

   task automatic cnt_until(input logic lvl, input int lim, output int cnt);
      cnt = 0;
      while (txd !== lvl && cnt < lim) begin
         @(posedge clk);
         cnt++;
      end
   endtask

   task automatic get_frame(output logic [10:0] f);
      while (i_peer.got_q.size() == 0) begin
         @(posedge clk);
      end
      f = i_peer.got_q.pop_front();
      repeat (16) @(posedge clk);
   endtask

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   initial begin
      clk = 1'b0;
      rst = 1'b1;
      addr = 3'h0;
      wdata = 8'h00;
      wr = 1'b0;
      rd = 1'b0;
      nine = 1'b0;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      // Reset state and an unmapped address
      chk("txd idle", 1'h1, txd);
      chk("txd oe", 1'h0, oe);
      rd_reg(ADR_SR1, d);
      chk("empty after reset", 1'h1, d[SR1_TX_BUFFER_EMPTY_FLAG]);
      rd_reg(3'h7, d);
      chk("unmapped read", 8'h00, d);
      $display("reset test done");
      // Divisor zero holds everything; the preamble comes first once it runs
      wr_reg(ADR_CR2, 8'h0c);
      wr_reg(ADR_DRL, 8'ha5);
      rd_reg(ADR_SR1, d);
      chk("empty after write", 1'h0, d[SR1_TX_BUFFER_EMPTY_FLAG]);
      repeat (400) @(posedge clk);
      chk("line at divisor zero", 1'h1, txd);
      chk("frames at divisor zero", 16'h0000, 16'(i_peer.got_q.size()));
      wr_reg(ADR_DIV_HI, 8'h00);
      wr_reg(ADR_DIV_LO, 8'h01);
      cnt_until(1'b0, 4000, n);
      chk("preamble length", 1'h1, n >= 160 && n <= 180);
      rd_reg(ADR_SR1, d);
      chk("empty after transfer", 1'h1, d[SR1_TX_BUFFER_EMPTY_FLAG]);
      get_frame(fr);
      chk("8-bit frame", {1'b1, 8'ha5, 1'b0}, fr);
      $display("preamble test done");
      // Back to back: next transfer 9/16 into the stop bit
      wr_reg(ADR_DRL, 8'h11);
      d = 8'h00;
      while (d[SR1_TX_BUFFER_EMPTY_FLAG] !== 1'b1) begin
         rd_reg(ADR_SR1, d);
      end
      wr_reg(ADR_DRL, 8'h22);
      d = 8'h00;
      while (d[SR1_TX_BUFFER_EMPTY_FLAG] !== 1'b1) begin
         rd_reg(ADR_SR1, d);
      end
      cnt_until(1'b0, 4000, n);
      chk("transfer to start", 1'h1, n >= 1 && n <= 8);
      get_frame(fr);
      chk("first of pair", {1'b1, 8'h11, 1'b0}, fr);
      get_frame(fr);
      chk("second of pair", {1'b1, 8'h22, 1'b0}, fr);
      $display("back to back test done");
      // Even then odd parity in the top data bit
      for (int odd = 0; odd < 2; odd++) begin
         wr_reg(ADR_CR1, 8'h02 | 8'(odd));
         wr_reg(ADR_DRL, 8'h01);
         get_frame(fr);
         chk("parity frame", {1'b1, (^7'h01) ^ odd[0], 7'h01, 1'b0}, fr);
      end
      $display("parity test done");
      // Nine-bit send, receive and received break
      nine = 1'b1;
      wr_reg(ADR_CR1, 8'h10);
      wr_reg(ADR_DRH, 8'h40);
      wr_reg(ADR_DRL, 8'h5a);
      get_frame(fr);
      chk("9-bit frame", {1'b1, 1'b1, 8'h5a, 1'b0}, fr);
      i_peer.send({1'b1, 1'b1, 8'h3c, 1'b0}, 11);
      repeat (20) @(posedge clk);
      rd_reg(ADR_DRH, d);
      chk("rx ninth bit", 1'h1, d[DRH_R8]);
      rd_reg(ADR_DRL, d);
      chk("rx data", 8'h3c, d);
      i_peer.send(11'h000, 11);
      repeat (20) @(posedge clk);
      rd_reg(ADR_SR1, d);
      chk("break flags", 8'h22, d & 8'h22);
      rd_reg(ADR_DRH, d);
      chk("break ninth bit", 1'h0, d[DRH_R8]);
      rd_reg(ADR_DRL, d);
      chk("break data", 8'h00, d);
      nine = 1'b0;
      wr_reg(ADR_CR1, 8'h00);
      $display("nine-bit test done");
      // Disable mid frame: frame completes, then the pin is released
      wr_reg(ADR_DRL, 8'h3c);
      cnt_until(1'b0, 4000, n);
      wr_reg(ADR_CR2, 8'h04);
      get_frame(fr);
      chk("frame after disable", {1'b1, 8'h3c, 1'b0}, fr);
      repeat (32) @(posedge clk);
      chk("pin released", 1'h0, oe);
      chk("line idle", 1'h1, txd);
      $display("disable test done");
      // Toggle during a frame queues one idle character
      wr_reg(ADR_CR2, 8'h0c);
      wr_reg(ADR_DRL, 8'h77);
      cnt_until(1'b0, 4000, n);
      rd_reg(ADR_SR1, d);
      chk("empty during frame", 1'h1, d[SR1_TX_BUFFER_EMPTY_FLAG]);
      wr_reg(ADR_CR2, 8'h04);
      wr_reg(ADR_CR2, 8'h0c);
      wr_reg(ADR_DRL, 8'h66);
      get_frame(fr);
      chk("frame before idle", {1'b1, 8'h77, 1'b0}, fr);
      cnt_until(1'b0, 4000, n);
      chk("queued idle", 1'h1, n >= 140);
      get_frame(fr);
      chk("frame after idle", {1'b1, 8'h66, 1'b0}, fr);
      $display("toggle test done");
      // Break: cleared mid character, one full zero run then ones
      wr_reg(ADR_CR2, 8'h0d);
      cnt_until(1'b0, 4000, n);
      t0 = cyc;
      repeat (100) @(posedge clk);
      wr_reg(ADR_CR2, 8'h0c);
      cnt_until(1'b1, 4000, n);
      chk("break length", 1'h1, cyc - t0 >= 158 && cyc - t0 <= 162);
      cnt_until(1'b0, 200, n);
      chk("ones after break", 1'h1, n >= 16);
      i_peer.got_q.delete();
      $display("break test done");
      // Interrupt follows its enable while the empty flag is set
      wr_reg(ADR_CR2, 8'h8c);
      repeat (3) @(posedge clk);
      chk("irq on", 1'h1, irq);
      wr_reg(ADR_CR2, 8'h0c);
      repeat (3) @(posedge clk);
      chk("irq off", 1'h0, irq);
      $display("irq test done");
      report_and_stop();
   end
endmodule
